//--- rtl/acd_cmd_decoder.sv
// command decoder for a multichannel converter behind a serial link
// assumes convDone and convData come from the conversion core on clk
//
// Notes on behaviour
// (R1) standby command powers down all but the reference until wake-up
// (R2) host sends only wake-up while in standby
// (R3) reset command restarts filter, restores register defaults in 18 cycles
// (R4) host sends nothing during the 18 cycles after reset
// (R5) start command begins conversions; ignored when already running
// (R6) host holds start pin low while controlling conversions by command
// (R7) host leaves at least 4 cycles between start and a following stop
// (R8) stop lets current conversion finish, then no more; idle if stopped
// (R9) continuous mode loads each result at data-ready; default after reset
// (R10) in continuous mode host sends stop-continuous before anything else
// (R11) host keeps continuous command 4 cycles clear of data-ready
// (R12) host waits 4 cycles after continuous command before more clocks
// (R13) idle output line follows data-ready while in continuous mode
// (R14) host makes conversions run before expecting read data
// (R15) host does not read during the 4-cycle output update interval
// (R16) host waits 4 cycles after stop-continuous before next command
// (R17) single read loads latest result when not in continuous mode
// (R18) single-read transfer survives a later data-ready uncorrupted
// (R19) register read: 001 plus address, then 000 plus count minus one
// (R20) first read register MSB leaves on rising edge 17, then consecutive
// (R21) register write: 010 plus address, count byte, then data MSB first
// (R22) host holds chip select low for a whole multi-byte command
// (R23) host leaves 4 cycles between bytes for decode and execute
// (R24) system opcodes: wake 02h, standby 04h, reset 06h, start 08h, stop 0Ah
// (R25) read opcodes: continuous 10h, stop continuous 11h, single 12h
// (R26) input sampled on falling serial edges, output changed on rising
`timescale 1ns/10ps
`default_nettype none
module acd_cmd_decoder
  import acd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             sclk,
  input  wire logic             csN,
  input  wire logic             din,
  input  wire logic             startPin,
  input  wire logic             convDone,
  input  wire logic [OUT_W-1:0] convData,
  output logic                  dout,
  output logic                  doutOe,
  output logic                  dataReadyN,
  output logic                  convRun,
  output logic                  filterRestart,
  output logic                  powerDown,
  output logic [REG_W-1:0]      cfgRegs
);
  acd_state_t       state_r, state_nxt;
  logic [1:0]       rxSync_r;
  logic             rxPrev_r;
  logic [1:0]       csSync_r;
  logic [1:0]       startSync_r;
  logic [7:0]       rxByte;
  logic             rxTog;
  logic             linkBit;
  logic             linkIdle;
  logic             standby_r;
  logic             contMode_r;
  logic             cmdRun_r;
  logic             stopPend_r;
  logic             resetBusy_r;
  logic [4:0]       resetCnt_r;
  logic             updBusy_r;
  logic [2:0]       updCnt_r;
  logic             dataReadyN_r;
  logic [4:0]       addr_r;
  logic [4:0]       count_r;
  logic             isWrite_r;
  logic [OUT_W-1:0] latest_r;
  logic [OUT_W-1:0] outWord_r;
  logic [8:0]       outBase_r;
  acd_wr_t          regWr;

  function automatic logic [OUT_W-1:0] reg_window(
    input logic [REG_W-1:0] regs, input logic [4:0] start);
    logic [REG_W-1:0] sh;
    sh = regs << {start, 3'h0};
    return {sh, {(OUT_W-REG_W){1'b0}}};
  endfunction

  acd_serial_link u_link (
    .sclk      (sclk),
    .rst_n     (rst_n),
    .csN       (csN),
    .din       (din),
    .outWord   (outWord_r),
    .outBase   (outBase_r),
    .rxByte_r  (rxByte),
    .rxTog_r   (rxTog),
    .doutBit_r (linkBit),
    .frameIdle (linkIdle)
  );

  acd_reg_file u_regs (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (resetBusy_r),
    .wr    (regWr),
    .regs  (cfgRegs)
  );

  // the first flop of each synchroniser only feeds the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxSync_r    <= 2'h0;
      rxPrev_r    <= 1'b0;
      csSync_r    <= 2'h3;
      startSync_r <= 2'h0;
    end else begin
      rxSync_r    <= {rxSync_r[0], rxTog};
      rxPrev_r    <= rxSync_r[1];
      csSync_r    <= {csSync_r[0], csN};
      startSync_r <= {startSync_r[0], startPin};
    end
  end

  // byte data is stable for a whole byte time once its toggle is seen
  wire rxEv     = rxSync_r[1] ^ rxPrev_r;
  wire csHigh   = csSync_r[1];
  wire startLvl = startSync_r[1];

  wire isWake   = rxByte == OP_WAKEUP;
  wire isStopRd = rxByte == OP_STOP_RD;
  wire cmdOk    = rxEv && state_r == ST_IDLE && !resetBusy_r &&
                  !(standby_r && !isWake) &&
                  !(contMode_r && !isStopRd);
  wire wakeEv   = cmdOk && isWake;
  wire stbyEv   = cmdOk && rxByte == OP_STANDBY; // R24
  wire resetEv  = cmdOk && rxByte == OP_RESET; // R24
  wire startEv  = cmdOk && rxByte == OP_START; // R24
  wire stopEv   = cmdOk && rxByte == OP_STOP; // R24
  wire contEv   = cmdOk && rxByte == OP_CONT_RD; // R25
  wire stopRdEv = cmdOk && isStopRd; // R25
  wire singleEv = cmdOk && rxByte == OP_SINGLE; // R25 R17
  wire rregHead = cmdOk && rxByte[7:5] == PFX_REGISTER_READ_CMD; // R19
  wire wregHead = cmdOk && rxByte[7:5] == PFX_REGISTER_WRITE_CMD; // R21
  wire cntByte  = rxEv && state_r == ST_COUNT && rxByte[7:5] == PFX_COUNT;
  wire rregLoad = cntByte && !isWrite_r; // R19
  wire dataByte = rxEv && state_r == ST_WDATA;
  wire runNow   = cmdRun_r || startLvl;

  assign regWr.en   = dataByte; // R21
  assign regWr.addr = addr_r;
  assign regWr.data = rxByte;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rregHead || wregHead) state_nxt = ST_COUNT;
      end
      ST_COUNT: begin
        if (rxEv) state_nxt = (cntByte && isWrite_r) ? ST_WDATA : ST_IDLE;
      end
      ST_WDATA: begin
        if (dataByte && count_r == 5'h00) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // a dropped chip select abandons a half-sent command
    if (csHigh) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      addr_r    <= 5'h00;
      count_r   <= 5'h00;
      isWrite_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (rregHead || wregHead) begin
        addr_r    <= rxByte[4:0]; // R19 R21
        isWrite_r <= wregHead;
      end else if (dataByte) begin
        addr_r  <= addr_r + 5'h01;
        count_r <= count_r - 5'h01;
      end
      if (cntByte) count_r <= rxByte[4:0]; // R19
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_r   <= 1'b0;
      resetBusy_r <= 1'b0;
      resetCnt_r  <= 5'h00;
    end else begin
      if (stbyEv) standby_r <= 1'b1; // R1
      else if (wakeEv) standby_r <= 1'b0;
      if (resetEv) begin
        resetBusy_r <= 1'b1; // R3
        resetCnt_r  <= RESET_LAST;
      end else if (resetBusy_r) begin
        if (resetCnt_r == 5'h00) resetBusy_r <= 1'b0;
        else resetCnt_r <= resetCnt_r - 5'h01;
      end
    end
  end

  // continuous read is the mode that reset brings up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      contMode_r <= 1'b1; // R9
      cmdRun_r   <= 1'b0;
      stopPend_r <= 1'b0;
    end else begin
      if (contEv) contMode_r <= 1'b1;
      else if (stopRdEv) contMode_r <= 1'b0;
      if (startEv && !cmdRun_r) begin
        cmdRun_r <= 1'b1; // R5
      end else if (convDone && stopPend_r) begin
        cmdRun_r <= 1'b0; // R8
      end
      if (stopEv && cmdRun_r) stopPend_r <= 1'b1; // R8
      else if (convDone) stopPend_r <= 1'b0;
    end
  end

  // data-ready stays high through the output update interval
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      updBusy_r    <= 1'b0;
      updCnt_r     <= 3'h0;
      dataReadyN_r <= 1'b1;
    end else begin
      if (convDone) begin
        updBusy_r    <= 1'b1;
        updCnt_r     <= UPDATE_LAST;
        dataReadyN_r <= 1'b1;
      end else if (updBusy_r) begin
        if (updCnt_r == 3'h0) begin
          updBusy_r    <= 1'b0;
          dataReadyN_r <= 1'b0;
        end else begin
          updCnt_r <= updCnt_r - 3'h1;
        end
      end else if (rxEv) begin
        dataReadyN_r <= 1'b1;
      end
    end
  end

  // outside continuous mode the shift word changes only on a read command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latest_r  <= '0;
      outWord_r <= '0;
      outBase_r <= BASE_CONT;
    end else begin
      if (convDone) latest_r <= convData;
      if (contMode_r && convDone) begin
        outWord_r <= convData; // R9
        outBase_r <= BASE_CONT;
      end else if (singleEv) begin
        outWord_r <= latest_r; // R17 R18
        outBase_r <= BASE_SINGL;
      end else if (rregLoad) begin
        outWord_r <= reg_window(cfgRegs, addr_r); // R20
        outBase_r <= BASE_REGISTER_READ_CMD; // R20
      end
    end
  end

  assign dout          = (contMode_r && linkIdle) ? dataReadyN_r : linkBit; // R13
  assign doutOe        = !csN;
  assign dataReadyN    = dataReadyN_r;
  assign convRun       = runNow;
  assign filterRestart = resetBusy_r; // R3
  assign powerDown     = standby_r; // R1

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_standby_enter:  assert property (stbyEv |=> powerDown [*2]) // R1
    else $error("standby did not power down");
  a_standby_wake:   assert property (standby_r && wakeEv |=> !powerDown) // R1
    else $error("wake-up did not leave standby");
  a_reset_length:   assert property ($rose(resetBusy_r) |->
    resetBusy_r [*8] ##1 resetBusy_r [*8] ##1 resetBusy_r [*2]
    ##1 !resetBusy_r) // R3
    else $error("reset busy time wrong");
  a_start_ignored:  assert property (startEv && cmdRun_r && !stopPend_r
    |=> cmdRun_r && !$changed(stopPend_r)) // R5
    else $error("start while running changed state");
  a_start_runs:     assert property (startEv && !cmdRun_r |=> convRun) // R5
    else $error("start did not begin conversions");
  a_stop_finishes:  assert property (stopEv && cmdRun_r && !convDone
    |=> cmdRun_r && stopPend_r) // R8
    else $error("stop cut the running conversion");
  a_cont_loads:     assert property (contMode_r && convDone
    |=> outWord_r == $past(convData) && outBase_r == BASE_CONT) // R9
    else $error("continuous result not loaded");
  a_single_loads:   assert property (singleEv && !convDone
    |=> outWord_r == $past(latest_r) && outBase_r == BASE_SINGL) // R17
    else $error("single read did not load result");
  a_single_holds:   assert property (!contMode_r && convDone && !singleEv &&
    !rregLoad |=> $stable(outWord_r)) // R18
    else $error("read word corrupted by data-ready");
  a_register_read_cmd_offset:    assert property (rregLoad && !convDone
    |=> outBase_r == BASE_REGISTER_READ_CMD) // R20
    else $error("register read start edge wrong");
  a_data_ready_n_update:    assert property (convDone ##1 !convDone [*4]
    |-> ##1 !dataReadyN_r) // R15
    else $error("data-ready not low after update");

  c_reg_write:  cover property (dataByte && count_r == 5'h00);
  c_reg_read:   cover property (rregLoad);
  c_single:     cover property (singleEv ##[1:50] convDone);
  c_standby:    cover property (stbyEv ##[1:200] wakeEv);
endmodule
`default_nettype wire

//--- include/acd_pkg.sv
// shared constants and types for the serial command decoder
// assumes the master clock is clk; one tCLK equals MCLK_DIV clk cycles
package acd_pkg;
  localparam int          MCLK_DIV    = 1;
  localparam int          RESET_TCLK  = 18;
  localparam int          UPDATE_TCLK = 4;
  localparam int          RESET_CYC   = RESET_TCLK * MCLK_DIV;
  localparam int          UPDATE_CYC  = UPDATE_TCLK * MCLK_DIV;
  localparam logic [4:0]  RESET_LAST  = 5'(RESET_CYC - 1);
  localparam logic [2:0]  UPDATE_LAST = 3'(UPDATE_CYC - 1);

  localparam int OUT_W    = 216;
  localparam int NUM_REGS = 24;
  localparam int REG_W    = 8 * NUM_REGS;

  localparam logic [7:0] OP_WAKEUP  = 8'h02;
  localparam logic [7:0] OP_STANDBY = 8'h04;
  localparam logic [7:0] OP_RESET   = 8'h06;
  localparam logic [7:0] OP_START   = 8'h08;
  localparam logic [7:0] OP_STOP    = 8'h0a;
  localparam logic [7:0] OP_CONT_RD = 8'h10;
  localparam logic [7:0] OP_STOP_RD = 8'h11;
  localparam logic [7:0] OP_SINGLE  = 8'h12;
  localparam logic [2:0] PFX_REGISTER_READ_CMD   = 3'h1;
  localparam logic [2:0] PFX_REGISTER_WRITE_CMD   = 3'h2;
  localparam logic [2:0] PFX_COUNT  = 3'h0;

  // rising sclk edges that pass before the first data bit of a frame
  localparam logic [8:0] BASE_CONT  = 9'h000;
  localparam logic [8:0] BASE_SINGL = 9'h008;
  localparam logic [8:0] BASE_REGISTER_READ_CMD  = 9'h010;

  localparam logic [4:0] ADDR_ID    = 5'h00;
  localparam logic [4:0] ADDR_STATP = 5'h12;
  localparam logic [4:0] ADDR_STATN = 5'h13;
  localparam logic [7:0] ID_CODE    = 8'h5a; // arbitrary value

  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } acd_wr_t;

  typedef enum {ST_IDLE, ST_COUNT, ST_WDATA} acd_state_t;

  function automatic logic [7:0] reg_default(input int idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == 0) v = ID_CODE;
    else if (idx == 1) v = 8'h96;
    else if (idx == 2) v = 8'hc0;
    else if (idx == 3) v = 8'h60;
    else if (idx >= 5 && idx <= 12) v = 8'h61;
    else if (idx == 20) v = 8'h0f;
    return v;
  endfunction
endpackage

//--- rtl/acd_reg_file.sv
// configuration register array with write port and default restore
// assumes writes come from the clk domain decoder
`timescale 1ns/10ps
`default_nettype none
module acd_reg_file
  import acd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire acd_wr_t          wr,
  output logic [REG_W-1:0]      regs
);
  logic [7:0] regMem_r [NUM_REGS];
  wire        readOnly = (wr.addr == ADDR_ID) || (wr.addr == ADDR_STATP) ||
                         (wr.addr == ADDR_STATN);
  wire        wrOk     = wr.en && !readOnly && (int'(wr.addr) < NUM_REGS);

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regMem_r[i] <= reg_default(i); // R3
      end
    end else if (wrOk) begin
      regMem_r[wr.addr] <= wr.data; // R21
    end
  end

  // register 0 sits in the top byte so a left shift selects a start address
  always_comb begin
    regs = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      regs[REG_W-1-8*i -: 8] = regMem_r[i];
    end
  end
endmodule
`default_nettype wire

//--- rtl/acd_serial_link.sv
// serial-clock side: byte capture on falling edges, output on rising edges
// assumes the output word is held stable by the decode gap before it is used
`timescale 1ns/10ps
`default_nettype none
module acd_serial_link
  import acd_pkg::*;
(
  input  wire logic             sclk,
  input  wire logic             rst_n,
  input  wire logic             csN,
  input  wire logic             din,
  input  wire logic [OUT_W-1:0] outWord,
  input  wire logic [8:0]       outBase,
  output logic [7:0]            rxByte_r,
  output logic                  rxTog_r,
  output logic                  doutBit_r,
  output logic                  frameIdle
);
  logic [2:0] bitCnt_r;
  logic [6:0] shift_r;
  logic [8:0] edgeCnt_r;
  wire  [8:0] bitIdx = edgeCnt_r - outBase;
  wire        inWord = (edgeCnt_r >= outBase) && (bitIdx < 9'(OUT_W));
  wire  [7:0] wordIdx = 8'(OUT_W - 1) - bitIdx[7:0];

  // chip select high restarts byte framing, as the host expects
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_r <= 3'h0;
      shift_r  <= 7'h00;
    end else begin
      bitCnt_r <= bitCnt_r + 3'h1; // R26
      shift_r  <= {shift_r[5:0], din}; // R26
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rxByte_r <= 8'h00;
      rxTog_r  <= 1'b0;
    end else if (!csN && bitCnt_r == 3'h7) begin
      rxByte_r <= {shift_r, din};
      rxTog_r  <= ~rxTog_r;
    end
  end

  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      edgeCnt_r <= 9'h000;
      doutBit_r <= 1'b0;
    end else begin
      if (edgeCnt_r != 9'h1ff) edgeCnt_r <= edgeCnt_r + 9'h001;
      doutBit_r <= inWord ? outWord[wordIdx] : 1'b0; // R20 R26
    end
  end

  assign frameIdle = (edgeCnt_r == 9'h000);
endmodule
`default_nettype wire

//--- tb/acd_host_model.sv
// host master model driving the serial link of the command decoder
// assumes a 48 ns serial clock that stands still low between frames
`timescale 1ns/10ps
`default_nettype none
module acd_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    din  = 1'b0;
  end

  task automatic open_frame();
    csN = 1'b0;
    #24;
  endtask

  // released line shows the inverse so a stale level cannot pass
  task automatic close_frame();
    #24;
    csN = 1'b1;
    din = ~din;
    #48;
  endtask

  // din set on rising edges, dout taken on falling edges
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din  = tx[i];
      #24;
      sclk  = 1'b0;
      rx[i] = dout;
      #24;
    end
    din = ~din;
    #48;
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    open_frame();
    xfer(op, rx);
    close_frame();
  endtask
endmodule
`default_nettype wire

//--- tb/acd_cmd_decoder_bench.sv
// self-checking bench for the serial command decoder
// assumes the host model owns the link and the bench drives the clk side
`timescale 1ns/10ps
`default_nettype none
module acd_cmd_decoder_bench
  import acd_pkg::*;
;
  logic             clk, rst_n, startPin, convDone;
  logic [OUT_W-1:0] convData;
  wire logic        sclk, csN, din, dout, doutOe;
  wire logic        dataReadyN, convRun, filterRestart, powerDown;
  wire logic [REG_W-1:0] cfgRegs;
  int               fails, total_checks;
  logic [7:0]       a, b;

  acd_cmd_decoder i_acd_cmd_decoder (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .din(din),
    .startPin(startPin), .convDone(convDone), .convData(convData),
    .dout(dout), .doutOe(doutOe), .dataReadyN(dataReadyN),
    .convRun(convRun), .filterRestart(filterRestart),
    .powerDown(powerDown), .cfgRegs(cfgRegs));

  acd_host_model i_acd_host_model (
    .sclk(sclk), .csN(csN), .din(din), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] regv(input int i);
    return cfgRegs[REG_W-1-8*i -: 8];
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic pulse(input logic [15:0] v);
    @(negedge clk);
    convData = {v, {(OUT_W-16){1'b1}}};
    convDone = 1'b1;
    @(negedge clk);
    convDone = 1'b0;
  endtask

  // bounded wait for the end of the output update interval
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (dataReadyN !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (dataReadyN !== 1'b0) begin
      chk("dataReadyN wait", 16'h0, 16'(dataReadyN));
      print_verdict();
    end
  endtask

  task automatic t_cont(input logic [15:0] v);
    pulse(v);
    wait_ready();
    i_acd_host_model.open_frame();
    chk("doutOe", 16'h1, 16'(doutOe));
    chk("dout idle", 16'h0, 16'(dout));
    i_acd_host_model.xfer(8'h00, a);
    i_acd_host_model.xfer(8'h00, b);
    i_acd_host_model.close_frame();
    chk("cont data", v, {a, b});
  endtask

  task automatic t_wr_rd();
    i_acd_host_model.cmd(8'h11);
    i_acd_host_model.open_frame();
    i_acd_host_model.xfer(8'h41, a);
    i_acd_host_model.xfer(8'h01, a);
    i_acd_host_model.xfer(8'h55, a);
    i_acd_host_model.xfer(8'haa, a);
    i_acd_host_model.close_frame();
    chk("reg01", 16'h55, 16'(regv(1)));
    chk("reg02", 16'haa, 16'(regv(2)));
    i_acd_host_model.open_frame();
    i_acd_host_model.xfer(8'h21, a);
    i_acd_host_model.xfer(8'h01, a);
    i_acd_host_model.xfer(8'h00, a);
    i_acd_host_model.xfer(8'h00, b);
    i_acd_host_model.close_frame();
    chk("reg read", 16'h55aa, {a, b});
  endtask

  // a data-ready in mid-transfer must not touch the loaded result
  task automatic t_single();
    pulse(16'hc3a5);
    wait_ready();
    i_acd_host_model.open_frame();
    i_acd_host_model.xfer(8'h12, a);
    fork
      i_acd_host_model.xfer(8'h00, a);
      begin
        repeat (4) @(negedge clk);
        pulse(16'h1234);
      end
    join
    i_acd_host_model.xfer(8'h00, b);
    i_acd_host_model.close_frame();
    chk("single data", 16'hc3a5, {a, b});
  endtask

  task automatic t_startstop();
    i_acd_host_model.cmd(8'h08);
    chk("convRun start", 16'h1, 16'(convRun));
    i_acd_host_model.cmd(8'h08);
    chk("convRun restart", 16'h1, 16'(convRun));
    i_acd_host_model.cmd(8'h0a);
    chk("convRun draining", 16'h1, 16'(convRun));
    pulse(16'h0000);
    repeat (3) @(negedge clk);
    chk("convRun stopped", 16'h0, 16'(convRun));
    i_acd_host_model.cmd(8'h0a);
    chk("convRun still", 16'h0, 16'(convRun));
  endtask

  // pin-driven conversions pass the two-flop synchroniser before use
  task automatic t_pin();
    @(negedge clk);
    startPin = 1'b1;
    repeat (3) @(negedge clk);
    chk("convRun pin high", 16'h1, 16'(convRun));
    startPin = 1'b0;
    repeat (3) @(negedge clk);
    chk("convRun pin low", 16'h0, 16'(convRun));
  endtask

  task automatic t_standby();
    i_acd_host_model.cmd(8'h04);
    chk("powerDown on", 16'h1, 16'(powerDown));
    i_acd_host_model.cmd(8'h02);
    chk("powerDown off", 16'h0, 16'(powerDown));
  endtask

  task automatic t_reset();
    int n;
    n = 0;
    fork
      i_acd_host_model.cmd(8'h06);
      repeat (200) begin
        @(negedge clk);
        if (filterRestart === 1'b1) n++;
      end
    join
    chk("filterRestart cycles", 16'd18, 16'(n));
    chk("reg01 default", 16'h96, 16'(regv(1)));
    chk("reg02 default", 16'hc0, 16'(regv(2)));
    chk("reg03 default", 16'h60, 16'(regv(3)));
    chk("reg14 default", 16'h0f, 16'(regv(20)));
  endtask

  // a real falling edge so the link's asynchronous reset is seen
  initial begin
    rst_n        = 1'b1;
    #1;
    rst_n        = 1'b0;
    startPin     = 1'b0;
    convDone     = 1'b0;
    convData     = '0;
    fails        = 0;
    total_checks = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("dataReadyN reset", 16'h1, 16'(dataReadyN));
    t_cont(16'ha5c3);
    t_wr_rd();
    t_single();
    t_startstop();
    t_pin();
    t_standby();
    t_reset();
    i_acd_host_model.cmd(8'h10);
    t_cont(16'h5a96);
    print_verdict();
  end
endmodule
`default_nettype wire
